// ### spm_pkg.sv
package spm_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] SPM_OFF_SMI_CONTROL = 8'ha0;
    localparam logic [7:0] SPM_OFF_SRC_EN_LO = 8'ha2;
    localparam logic [7:0] SPM_OFF_SRC_EN_HI = 8'ha3;
    localparam logic [7:0] SPM_OFF_IDLE_TIMER = 8'ha8;
    localparam logic [7:0] SPM_OFF_REQUEST_LO = 8'haa;
    localparam logic [7:0] SPM_OFF_REQUEST_HI = 8'hab;
    localparam logic [7:0] SPM_OFF_SYS_EV_0 = 8'hac;
    localparam logic [7:0] SPM_OFF_SYS_EV_1 = 8'had;
    localparam logic [7:0] SPM_OFF_SYS_EV_2 = 8'hae;
    localparam logic [7:0] SPM_OFF_SYS_EV_3 = 8'haf;
    localparam logic [7:0] SPM_OFF_STATUS = 8'hb0;
    localparam logic [7:0] SPM_OFF_THROTTLE_LOW = 8'hb2;
    localparam logic [7:0] SPM_OFF_THROTTLE_HIGH = 8'hb3;
    // smi_control fields
    localparam int SPM_CTL_GATE = 0;
    localparam int SPM_CTL_STPEN = 1;
    localparam int SPM_CTL_THROTTLE = 2;
    localparam int SPM_CTL_FREEZE = 3;
    localparam int SPM_CTL_NOWAIT = 6;
    localparam logic [7:0] SPM_CTL_MASK = 8'h4f;
    // source-enable / request bit positions
    localparam int SPM_SRC_PORT = 7;
    localparam int SPM_SRC_EXT = 6;
    localparam int SPM_SRC_IDLE = 5;
    // system event enable fields
    localparam int SPM_SEE_SMI = 31;
    localparam int SPM_SEE_NMI = 29;
    localparam int SPM_SEE_COM = 27;
    localparam int SPM_SEE_LPT = 26;
    localparam int SPM_SEE_DRV = 25;
    localparam int SPM_SEE_DMA = 24;
    localparam logic [31:0] SPM_SEE_MASK = 32'haf00_fffb;
    // reset values
    localparam logic [7:0] SPM_RST_CONTROL = 8'h00;
    localparam logic [7:0] SPM_RST_SRC_EN = 8'h00;
    localparam logic [31:0] SPM_RST_SEE = 32'h0000_0000;
    localparam logic [7:0] SPM_RST_TIMER = 8'h00;
    localparam logic [7:0] SPM_RST_THROTTLE = 8'h01;
    // timing: one idle tick per minute, throttle tick every 32 us
    localparam longint SPM_MINUTE_NS = 64'd60_000_000_000;
    localparam longint SPM_CLK_NS = 64'd10;
    localparam longint SPM_MINUTE_CYCLES = SPM_MINUTE_NS / SPM_CLK_NS;
    localparam int SPM_THROTTLE_TICK_US = 32;
    localparam int SPM_THROTTLE_TICK_CYCLES = int'(SPM_THROTTLE_TICK_US * 1000 / SPM_CLK_NS);
endpackage

// ### spm_power_mgmt.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
// Behaviour
// [R1] nowait bit 0: hold stop-clock until stop grant; 1: release without waiting
// [R2] timer freeze holds the idle countdown
// [R3] throttle enable toggles the stop-clock request periodically
// [R4] with stop-clock sw enable set, control port read asserts stop-clock
// [R5] stop-clock sw enable clears on write of 0 or any control port write
// [R6] gate write 0 releases interrupt; write 1 asserts it if requests pend
// [R7] enabled sources (port write, external, idle, five lines) raise requests
// [R8] source enable upper byte reads zero and ignores writes
// [R9] enabled system event reloads the idle countdown
// [R10] enabled system event is a break event releasing stop-clock
// [R11] bit 31 makes interrupt, bit 29 makes nonmaskable a system event
// [R12] serial port ranges are system events when enabled
// [R13] parallel port ranges are system events when enabled
// [R14] disk drive ranges are system events when enabled
// [R15] dma controller accesses are system events when enabled
// [R16] per-line event enables at 15..3 and 1..0, bit 2 reads zero
// [R17] idle countdown decrements once per minute
// [R18] idle expiry produces a management interrupt cycle
// [R19] countdown reaching zero signals expiry unless reloaded first
// [R20] request bits set by hardware, cleared by writing 0, set wins
// [R21] reset returns all registers to defaults, sources disabled
module spm_power_mgmt
    import spm_pkg::*;
#(
    parameter longint MINUTE_CYCLES = spm_pkg::SPM_MINUTE_CYCLES,
    parameter int THROTTLE_TICK_CYCLES = spm_pkg::SPM_THROTTLE_TICK_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // observed io cycles (same clock)
    input wire logic io_valid,
    input wire logic [15:0] io_addr,
    input wire logic dma_access,
    input wire logic power_ctrl_port_write,
    input wire logic power_ctrl_port_read,
    input wire logic stop_grant_cycle,
    // asynchronous event pins
    input wire logic [15:0] irq_lines,
    input wire logic nmi_event,
    input wire logic external_mgmt_request_n,
    // processor side
    output logic mgmt_interrupt_n,
    output logic stop_clock_request_n,
    output logic idle_expired
);
    import spm_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [17:0] sync_a;
    logic [17:0] sync_b;
    logic [17:0] sync_prev;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_prev <= '0;
        end else begin
            sync_a <= {nmi_event, ~external_mgmt_request_n, irq_lines};
            sync_b <= sync_a;
            sync_prev <= sync_b;
        end
    end
    // rising edges only: a held line is one event, not a stream
    wire [17:0] pin_rise = sync_b & ~sync_prev;
    wire [15:0] irq_rise = pin_rise[15:0];
    wire ext_rise = pin_rise[16];
    wire nmi_rise = pin_rise[17];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] smi_control;
    logic [7:0] smi_source_enable;
    logic [31:0] system_event_enable;
    logic [7:0] idle_timer_count;
    logic [7:0] smi_request;
    logic [7:0] throttle_low;
    logic [7:0] throttle_high;
    logic [7:0] idle_count;
    logic smi_active;
    logic stop_req;

    wire wr_ctl = reg_write && reg_addr == SPM_OFF_SMI_CONTROL;
    wire wr_src = reg_write && reg_addr == SPM_OFF_SRC_EN_LO;
    wire wr_tmr = reg_write && reg_addr == SPM_OFF_IDLE_TIMER;
    wire wr_req = reg_write && reg_addr == SPM_OFF_REQUEST_LO;
    wire wr_tl = reg_write && reg_addr == SPM_OFF_THROTTLE_LOW;
    wire wr_th = reg_write && reg_addr == SPM_OFF_THROTTLE_HIGH;
    wire [3:0] wr_see = {reg_write && reg_addr == SPM_OFF_SYS_EV_3,
                         reg_write && reg_addr == SPM_OFF_SYS_EV_2,
                         reg_write && reg_addr == SPM_OFF_SYS_EV_1,
                         reg_write && reg_addr == SPM_OFF_SYS_EV_0};

    wire freeze = smi_control[SPM_CTL_FREEZE];
    wire nowait = smi_control[SPM_CTL_NOWAIT];
    wire throttle_en = smi_control[SPM_CTL_THROTTLE];

    // ----------------------------------------
    // io range decode
    // ----------------------------------------
    wire [15:0] a = io_addr;
    wire hit_com = io_valid && (a[15:3] == 13'h05d || a[15:3] == 13'h05f ||
                                a[15:3] == 13'h07d || a[15:3] == 13'h07f); // [R12]
    wire hit_lpt = io_valid && (a[15:3] == 13'h04f || a[15:3] == 13'h06f ||
                                a[15:2] == 14'h00ef); // [R13]
    wire hit_drv = io_valid && (a[15:4] == 12'h01f || a[15:4] == 12'h017 ||
                                a[15:4] == 12'h032 || a[15:3] == 13'h07e ||
                                a[15:3] == 13'h06e); // [R14]

    // ----------------------------------------
    // event sources
    // ----------------------------------------
    wire [7:0] src_event = {power_ctrl_port_write, ext_rise, idle_expired,
                            irq_rise[12], irq_rise[8], irq_rise[4], irq_rise[3], irq_rise[1]};
    wire [7:0] src_fire = src_event & smi_source_enable; // [R7]
    wire smi_fire = |src_fire;
    wire [15:0] line_en = system_event_enable[15:0] & SPM_SEE_MASK[15:0]; // [R16]
    wire sys_event = (system_event_enable[SPM_SEE_SMI] && smi_fire) ||
                     (system_event_enable[SPM_SEE_NMI] && nmi_rise) || // [R11]
                     (system_event_enable[SPM_SEE_COM] && hit_com) ||
                     (system_event_enable[SPM_SEE_LPT] && hit_lpt) ||
                     (system_event_enable[SPM_SEE_DRV] && hit_drv) ||
                     (system_event_enable[SPM_SEE_DMA] && dma_access) || // [R15]
                     (|(irq_rise & line_en));

    // ----------------------------------------
    // control and enable registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            smi_control <= SPM_RST_CONTROL; // [R21]
            smi_source_enable <= SPM_RST_SRC_EN;
            system_event_enable <= SPM_RST_SEE;
            idle_timer_count <= SPM_RST_TIMER;
            throttle_low <= SPM_RST_THROTTLE;
            throttle_high <= SPM_RST_THROTTLE;
        end else begin
            if (wr_ctl)
                smi_control <= reg_wdata & SPM_CTL_MASK;
            else if (power_ctrl_port_write)
                smi_control[SPM_CTL_STPEN] <= 1'b0; // [R5]
            if (wr_src)
                smi_source_enable <= reg_wdata; // upper byte has no storage [R8]
            for (int i = 0; i < 4; i++) begin
                if (wr_see[i])
                    system_event_enable[i*8 +: 8] <= reg_wdata & SPM_SEE_MASK[i*8 +: 8];
            end
            if (wr_tmr)
                idle_timer_count <= reg_wdata;
            if (wr_tl)
                throttle_low <= reg_wdata;
            if (wr_th)
                throttle_high <= reg_wdata;
        end
    end

    // ----------------------------------------
    // request status and interrupt output
    // ----------------------------------------
    wire [7:0] req_keep = wr_req ? (smi_request & reg_wdata) : smi_request;
    wire [7:0] next_request = req_keep | src_fire; // set wins [R20]
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            smi_request <= '0;
            smi_active <= 1'b0;
        end else begin
            smi_request <= next_request;
            if (wr_ctl && !reg_wdata[SPM_CTL_GATE])
                smi_active <= 1'b0; // [R6]
            else if (wr_ctl)
                smi_active <= |next_request; // [R6]
            else if (smi_fire && smi_control[SPM_CTL_GATE])
                smi_active <= 1'b1; // [R7] [R18]
        end
    end
    assign mgmt_interrupt_n = ~smi_active;

    // ----------------------------------------
    // idle countdown
    // ----------------------------------------
    logic [$clog2(MINUTE_CYCLES+1)-1:0] minute_cnt;
    wire minute_tick = minute_cnt == '0;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            minute_cnt <= '0;
            idle_count <= SPM_RST_TIMER;
            idle_expired <= 1'b0;
        end else begin
            idle_expired <= 1'b0;
            if (freeze || sys_event || minute_tick)
                minute_cnt <= $bits(minute_cnt)'(MINUTE_CYCLES - 1);
            else
                minute_cnt <= minute_cnt - 1'b1; // [R17]
            if (wr_tmr && freeze)
                idle_count <= reg_wdata;
            else if (sys_event)
                idle_count <= idle_timer_count; // [R9]
            else if (!freeze && minute_tick && idle_count != 8'h00) begin // [R2]
                idle_count <= idle_count - 8'h01; // [R17]
                if (idle_count == 8'h01)
                    idle_expired <= 1'b1; // [R19] [R18]
            end
        end
    end

    // ----------------------------------------
    // stop-clock request and throttle
    // ----------------------------------------
    typedef enum logic [1:0] {SPM_RUN, SPM_WAIT_GRANT, SPM_STOPPED, SPM_THR_HIGH} spm_stp_t;
    spm_stp_t stp_state;
    logic [$clog2(THROTTLE_TICK_CYCLES+1)-1:0] tick_cnt;
    logic [7:0] thr_cnt;
    logic brk_seen;
    wire thr_tick = tick_cnt == '0;
    wire sw_stop = power_ctrl_port_read && smi_control[SPM_CTL_STPEN]; // [R4]
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stp_state <= SPM_RUN;
            tick_cnt <= '0;
            thr_cnt <= '0;
            brk_seen <= 1'b0;
        end else begin
            // a break before the grant is kept until the grant lands
            brk_seen <= stp_state == SPM_WAIT_GRANT && (brk_seen || sys_event); // [R10]
            tick_cnt <= thr_tick ? $bits(tick_cnt)'(THROTTLE_TICK_CYCLES - 1) : tick_cnt - 1'b1;
            unique case (stp_state)
                SPM_RUN: begin
                    if (sw_stop || throttle_en) begin // [R3] [R4]
                        stp_state <= SPM_WAIT_GRANT;
                        thr_cnt <= throttle_low;
                    end
                end
                SPM_WAIT_GRANT: begin
                    // low period only counts after the grant arrives, or at once when nowait is set
                    if ((sys_event || brk_seen) && (nowait || stop_grant_cycle))
                        stp_state <= SPM_RUN; // [R10] [R1]
                    else if (stop_grant_cycle || nowait)
                        stp_state <= SPM_STOPPED; // [R1]
                end
                SPM_STOPPED: begin
                    if (sys_event)
                        stp_state <= SPM_RUN; // [R10]
                    else if (throttle_en && thr_tick) begin
                        if (thr_cnt <= 8'h01) begin
                            stp_state <= SPM_THR_HIGH; // [R3]
                            thr_cnt <= throttle_high;
                        end else
                            thr_cnt <= thr_cnt - 8'h01;
                    end
                end
                SPM_THR_HIGH: begin
                    if (!throttle_en || sys_event)
                        stp_state <= SPM_RUN;
                    else if (thr_tick) begin
                        if (thr_cnt <= 8'h01) begin
                            stp_state <= SPM_WAIT_GRANT; // [R3]
                            thr_cnt <= throttle_low;
                        end else
                            thr_cnt <= thr_cnt - 8'h01;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            stop_req <= 1'b0;
        else
            stop_req <= stp_state == SPM_WAIT_GRANT || stp_state == SPM_STOPPED;
    end
    assign stop_clock_request_n = ~stop_req;

    // ----------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            SPM_OFF_SMI_CONTROL: rd_mux = smi_control;
            SPM_OFF_SRC_EN_LO: rd_mux = smi_source_enable;
            SPM_OFF_IDLE_TIMER: rd_mux = idle_timer_count;
            SPM_OFF_REQUEST_LO: rd_mux = smi_request;
            SPM_OFF_SYS_EV_0: rd_mux = system_event_enable[7:0];
            SPM_OFF_SYS_EV_1: rd_mux = system_event_enable[15:8];
            SPM_OFF_SYS_EV_2: rd_mux = system_event_enable[23:16];
            SPM_OFF_SYS_EV_3: rd_mux = system_event_enable[31:24];
            SPM_OFF_STATUS: rd_mux = idle_count;
            SPM_OFF_THROTTLE_LOW: rd_mux = throttle_low;
            SPM_OFF_THROTTLE_HIGH: rd_mux = throttle_high;
            default: rd_mux = 8'h00; // [R8]
        endcase
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_read ? rd_mux : 8'h00;
    end
endmodule // spm_power_mgmt

// ### spm_power_mgmt_chk.sv
`timescale 1ns/1ns
module spm_power_mgmt_chk
    import spm_pkg::*;
#(
    parameter longint MINUTE_CYCLES = 20,
    parameter int THROTTLE_TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // observed cycles and events
    input wire logic io_valid,
    input wire logic [15:0] io_addr,
    input wire logic dma_access,
    input wire logic power_ctrl_port_write,
    input wire logic power_ctrl_port_read,
    input wire logic stop_grant_cycle,
    input wire logic [15:0] irq_lines,
    input wire logic nmi_event,
    input wire logic external_mgmt_request_n,
    // processor side
    input wire logic mgmt_interrupt_n,
    input wire logic stop_clock_request_n,
    input wire logic idle_expired
);
    // ----
    // control bits shadowed from the register port
    // ----
    wire ctl_wr = reg_write && reg_addr == SPM_OFF_SMI_CONTROL;
    logic stpen, nowait, gate, frz, granted;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {stpen, nowait, gate, frz, granted} <= '0;
        end else begin
            granted <= !stop_clock_request_n && (granted || stop_grant_cycle);
            if (ctl_wr) begin
                {nowait, frz, stpen, gate} <= {reg_wdata[6], reg_wdata[3], reg_wdata[1:0]};
            end else if (power_ctrl_port_write) begin
                stpen <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    a_src_hi_zero: assert property (reg_read && reg_addr == SPM_OFF_SRC_EN_HI
        |=> reg_rdata == 8'h00) else $error("upper enable byte reads nonzero");
    a_see_bit2_zero: assert property (reg_read && reg_addr == SPM_OFF_SYS_EV_0
        |=> !reg_rdata[2]) else $error("reserved event bit reads one");
    a_gate_release: assert property (ctl_wr && !reg_wdata[0] |=> mgmt_interrupt_n)
        else $error("interrupt kept after gate cleared");
    a_fall_needs_gate: assert property ($fell(mgmt_interrupt_n) |-> gate)
        else $error("interrupt asserted with gate clear");
    a_swread_stop: assert property (power_ctrl_port_read && stpen
        |-> ##[1:3] !stop_clock_request_n) else $error("port read gave no stop request");
    a_grant_first: assert property ($rose(stop_clock_request_n) && !nowait |-> granted)
        else $error("stop request released before grant");
    a_freeze_holds: assert property (frz && $past(frz) && $past(frz, 2) |-> !idle_expired)
        else $error("idle expiry while frozen");
    a_expiry_pulse: assert property (idle_expired |=> !idle_expired)
        else $error("expiry pulse longer than one cycle");
    a_reset_quiet: assert property ($rose(resetn) |-> mgmt_interrupt_n &&
        stop_clock_request_n && !idle_expired) else $error("outputs active after reset");
    c_interrupt: cover property ($fell(mgmt_interrupt_n));
    c_stop_release: cover property ($rose(stop_clock_request_n));
    c_expiry: cover property (idle_expired);
endmodule // spm_power_mgmt_chk

bind spm_power_mgmt spm_power_mgmt_chk #(
    .MINUTE_CYCLES(MINUTE_CYCLES),
    .THROTTLE_TICK_CYCLES(THROTTLE_TICK_CYCLES)
) chk_u (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .io_valid, .io_addr, .dma_access, .power_ctrl_port_write, .power_ctrl_port_read,
    .stop_grant_cycle, .irq_lines, .nmi_event, .external_mgmt_request_n,
    .mgmt_interrupt_n, .stop_clock_request_n, .idle_expired
);

// ### spm_host_model.sv
`timescale 1ns/1ns
// processor side: one stop grant cycle per request, after a chosen delay
module spm_host_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // stop-clock handshake
    input wire logic stop_clock_request_n,
    input wire logic [7:0] grant_delay,
    output logic stop_grant_cycle
);
    logic [7:0] low_cycles;
    wire grant_due = !stop_clock_request_n && low_cycles == grant_delay;
    wire [7:0] step = (low_cycles == 8'hff) ? 8'h00 : 8'h01;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            low_cycles <= 8'h00;
            stop_grant_cycle <= 1'b0;
        end else begin
            low_cycles <= stop_clock_request_n ? 8'h00 : low_cycles + step;
            stop_grant_cycle <= grant_due;
        end
    end
endmodule // spm_host_model

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
    import spm_pkg::*;
    localparam int MINUTE = 20;
    localparam int LIMIT = 10000;
    logic core_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, grant_delay = 8'd30;
    logic io_valid = 1'b0, dma_access = 1'b0, nmi_event = 1'b0, external_mgmt_request_n = 1'b1;
    logic power_ctrl_port_write = 1'b0, power_ctrl_port_read = 1'b0, stop_grant_cycle;
    logic [15:0] io_addr = 16'h0000, irq_lines = 16'h0000;
    logic mgmt_interrupt_n, stop_clock_request_n, idle_expired;
    int errors = 0, n_compared = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    spm_power_mgmt #(.MINUTE_CYCLES(MINUTE), .THROTTLE_TICK_CYCLES(4)) dut_u (.core_clk,
        .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .io_valid, .io_addr,
        .dma_access, .power_ctrl_port_write, .power_ctrl_port_read, .stop_grant_cycle,
        .irq_lines, .nmi_event, .external_mgmt_request_n, .mgmt_interrupt_n,
        .stop_clock_request_n, .idle_expired);
    spm_host_model host_u (.core_clk, .resetn, .stop_clock_request_n, .grant_delay,
        .stop_grant_cycle);
    // ----
    // bus cycles and comparison
    // ----
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk(what, e, reg_rdata);
    endtask
    // zero address stands for a dma register access
    task automatic ev(input logic [15:0] a);
        @(posedge core_clk);
        io_addr <= a;
        io_valid <= (a != 16'h0000);
        dma_access <= (a == 16'h0000);
        @(posedge core_clk);
        io_valid <= 1'b0;
        dma_access <= 1'b0;
    endtask
    task automatic port(input logic is_read);
        @(posedge core_clk);
        power_ctrl_port_read <= is_read;
        power_ctrl_port_write <= !is_read;
        @(posedge core_clk);
        power_ctrl_port_read <= 1'b0;
        power_ctrl_port_write <= 1'b0;
    endtask
    task automatic wait_expiry(output int n);
        n = 0;
        while (idle_expired !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        logic [7:0] wa [8] = '{8'ha2, 8'ha3, 8'hac, 8'had, 8'hae, 8'haf, 8'ha0, 8'h10};
        logic [7:0] we [8] = '{8'hff, 8'h00, 8'hfb, 8'hff, 8'h00, 8'haf, 8'h08, 8'h00};
        foreach (wa[i]) rdchk("reset value", wa[i], 8'h00);
        rdchk("throttle high", SPM_OFF_THROTTLE_HIGH, SPM_RST_THROTTLE);
        foreach (wa[i]) begin
            wr(wa[i], (wa[i] == SPM_OFF_SMI_CONTROL) ? 8'hb8 : 8'hff);
            rdchk("readback", wa[i], we[i]);
            wr(wa[i], 8'h00);
        end
    endtask
    task automatic t_sources();
        int lines [5] = '{1, 3, 4, 8, 12};
        wr(SPM_OFF_SRC_EN_LO, 8'hdf);
        wr(SPM_OFF_SMI_CONTROL, 8'h09);
        for (int k = 0; k < 8; k++) begin
            if (k == 5) continue;
            @(posedge core_clk);
            if (k < 5) irq_lines <= 16'h0001 << lines[k];
            if (k == 6) external_mgmt_request_n <= 1'b0;
            if (k == 7) port(1'b0);
            tick(6);
            #1 chk("interrupt", 8'h00, {7'h00, mgmt_interrupt_n});
            rdchk("request", SPM_OFF_REQUEST_LO, 8'h01 << k);
            @(posedge core_clk);
            irq_lines <= 16'h0000;
            external_mgmt_request_n <= 1'b1;
            wr(SPM_OFF_REQUEST_LO, 8'h00);
            rdchk("request cleared", SPM_OFF_REQUEST_LO, 8'h00);
        end
        wr(SPM_OFF_SMI_CONTROL, 8'h08);
        #1 chk("gate off", 8'h01, {7'h00, mgmt_interrupt_n});
        wr(SPM_OFF_SMI_CONTROL, 8'h09);
        tick(1);
        #1 chk("gate idle", 8'h01, {7'h00, mgmt_interrupt_n});
        wr(SPM_OFF_SRC_EN_LO, 8'h00);
    endtask
    task automatic t_stop_wait();
        wr(SPM_OFF_SYS_EV_3, 8'h08);
        wr(SPM_OFF_SMI_CONTROL, 8'h02);
        port(1'b1);
        tick(3);
        #1 chk("stop on read", 8'h00, {7'h00, stop_clock_request_n});
        ev(16'h03f8);
        tick(3);
        #1 chk("held for grant", 8'h00, {7'h00, stop_clock_request_n});
        tick(30);
        #1 chk("after grant", 8'h01, {7'h00, stop_clock_request_n});
        wr(SPM_OFF_SMI_CONTROL, 8'h02);
        port(1'b0);
        rdchk("sw enable", SPM_OFF_SMI_CONTROL, 8'h00);
        port(1'b1);
        tick(3);
        #1 chk("no stop", 8'h01, {7'h00, stop_clock_request_n});
    endtask
    task automatic t_breaks();
        logic [7:0] en [9] = '{8'h08, 8'h08, 8'h04, 8'h04, 8'h02, 8'h02, 8'h02, 8'h01, 8'h04};
        logic [15:0] ad [9] = '{16'h02e8, 16'h03ff, 16'h0278, 16'h03bf, 16'h01f0, 16'h0377,
            16'h0320, 16'h0000, 16'h03f8};
        foreach (en[i]) begin
            wr(SPM_OFF_SYS_EV_3, en[i]);
            wr(SPM_OFF_SMI_CONTROL, 8'h42);
            port(1'b1);
            tick(3);
            ev(ad[i]);
            tick(3);
            #1 chk("break", (i == 8) ? 8'h00 : 8'h01, {7'h00, stop_clock_request_n});
        end
        wr(SPM_OFF_SYS_EV_3, 8'h08);
        ev(16'h03f8);
        tick(3);
        #1 chk("break com", 8'h01, {7'h00, stop_clock_request_n});
        wr(SPM_OFF_SRC_EN_LO, 8'h80);
        for (int j = 0; j < 2; j++) begin
            wr(SPM_OFF_SYS_EV_3, j ? 8'h20 : 8'h80);
            wr(SPM_OFF_SMI_CONTROL, 8'h42);
            port(1'b1);
            nmi_event <= j[0];
            port(j[0]);
            tick(5);
            nmi_event <= 1'b0;
            #1 chk("break smi nmi", 8'h01, {7'h00, stop_clock_request_n});
        end
        wr(SPM_OFF_REQUEST_LO, 8'h00);
    endtask
    task automatic t_idle();
        int n;
        wr(SPM_OFF_SRC_EN_LO, 8'h20);
        wr(SPM_OFF_SMI_CONTROL, 8'h08);
        wr(SPM_OFF_IDLE_TIMER, 8'h03);
        tick(100);
        rdchk("frozen count", SPM_OFF_STATUS, 8'h03);
        wr(SPM_OFF_SMI_CONTROL, 8'h01);
        wait_expiry(n);
        chk("expiry time", 8'h01, {7'h00, n >= 2 * MINUTE && n <= 4 * MINUTE});
        tick(2);
        #1 chk("idle interrupt", 8'h00, {7'h00, mgmt_interrupt_n});
        rdchk("idle request", SPM_OFF_REQUEST_LO, 8'h20);
        wr(SPM_OFF_REQUEST_LO, 8'h00);
        wr(SPM_OFF_SMI_CONTROL, 8'h08);
        wr(SPM_OFF_IDLE_TIMER, 8'h03);
        wr(SPM_OFF_SYS_EV_3, 8'h02);
        wr(SPM_OFF_SMI_CONTROL, 8'h00);
        tick(40);
        ev(16'h01f0);
        wait_expiry(n);
        chk("reloaded", 8'h01, {7'h00, n >= 2 * MINUTE && n <= 4 * MINUTE});
        wr(SPM_OFF_SMI_CONTROL, 8'h01);
        #1 chk("gate pending", 8'h00, {7'h00, mgmt_interrupt_n});
        wr(SPM_OFF_SRC_EN_LO, 8'h00);
    endtask
    task automatic t_throttle();
        int n;
        logic prev;
        n = 0;
        grant_delay <= 8'd2;
        wr(SPM_OFF_SMI_CONTROL, 8'h04);
        prev = stop_clock_request_n;
        repeat (300) begin
            @(posedge core_clk);
            #1 n += (stop_clock_request_n !== prev);
            prev = stop_clock_request_n;
        end
        chk("throttle edges", 8'h01, {7'h00, n >= 4});
    endtask
    initial begin
        tick(2);
        resetn <= 1'b1;
        t_regs();
        t_sources();
        t_stop_wait();
        t_breaks();
        t_idle();
        t_throttle();
        give_verdict();
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            give_verdict();
        end
    end
endmodule // testbench
